/* File: rtl/fsbc_host.sv */
// Purpose: Host controller issuing suspend, resume, bypass and accelerate sequences
// Assumes: Flash reports program completion on prog_busy; accel level driven here
// Notes: One request at a time; req_ready low while a sequence is running
// Overview of operation
// (RULE1) After suspend, wait the worst-case halt time before reading status.
// (RULE2) Suspend is one write of 00B0h at a don't-care address.
// (RULE3) While suspended, reads target other sectors only.
// (RULE4) Suspend allowed inside erase suspend; reads avoid both sectors.
// (RULE5) Identification reads allowed during suspend; mode returns to suspended.
// (RULE6) Resume is one write of 0030h at any address.
// (RULE7) After resume, further resumes are not sent; suspend may be sent again.
// (RULE8) Raising the accelerate level puts the device in bypass by itself.
// (RULE9) Buffer abort recovery in bypass uses the full three-cycle reset.
// (RULE10) Accelerate level drops only after the program completes.
// (RULE11) No sector gets accelerated programming more than ten times.
// (RULE12) Sectors are unlocked before accelerate is raised.
// (RULE13) Accelerate level is low outside accelerated programming.
// (RULE14) Program in bypass is two cycles without unlocks.
// (RULE15) In bypass only the permitted commands are sent.
// (RULE16) Bypass exit is 90h then 00h.
// (RULE17) Bypass entry is AAh at 555h, 55h at 2AAh, 20h at 555h.
// (RULE18) Suspend or resume with no program running is refused.
// (RULE19) Writes that start no permitted bypass command are never sent.
`timescale 1ns/1ps
module fsbc_host (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Request port
   input wire logic req_valid,
   input wire fsbc_pkg::fsbc_req_s req,
   output logic req_ready,
   output logic req_refused_q,
   // Status from the flash side
   input wire logic prog_busy,
   input wire logic sectors_unlocked,
   // Status to the user
   output logic bypass_q,
   output logic suspended_q,
   output logic [3:0] accel_count_q,
   // Flash pins
   output logic [23:0] flash_addr,
   output logic [15:0] flash_dq_out,
   output logic flash_dq_oe_n,
   output logic flash_ce_n,
   output logic flash_we_n,
   output logic accel_high_q
);
   typedef enum logic [1:0] {
      FSBC_IDLE = 2'b00,
      FSBC_WRITE = 2'b01,
      FSBC_WAIT = 2'b10,
      FSBC_HALT = 2'b11
   } fsbc_st_e;
   fsbc_st_e st_q, st_d;
   fsbc_pkg::fsbc_wr_s seq_q [3];
   fsbc_pkg::fsbc_wr_s seq_d [3];
   logic [1:0] idx_q, idx_d, len_q, len_d;
   logic [15:0] halt_q, halt_d;
   logic bypass_d, susp_d, accel_d, refused_d, halt_after_q, halt_after_d;
   logic [3:0] accel_cnt_d;
   logic wr_start, wr_done;

   // Write pulse generator
   fsbc_wr_cycle u_wr (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .start(wr_start),
      .wr(seq_q[idx_q]),
      .done(wr_done),
      .addr_q(flash_addr),
      .dq_out_q(flash_dq_out),
      .dq_oe_n_q(flash_dq_oe_n),
      .ce_n_q(flash_ce_n),
      .we_n_q(flash_we_n)
   );

   assign req_ready = (st_q == FSBC_IDLE);
   assign wr_start = (st_q == FSBC_WRITE);

   // Sequence selection and mode tracking
   always_comb begin
      st_d = st_q;
      idx_d = idx_q;
      len_d = len_q;
      halt_d = halt_q;
      bypass_d = bypass_q;
      susp_d = suspended_q;
      accel_d = accel_high_q;
      accel_cnt_d = accel_count_q;
      refused_d = 1'b0;
      halt_after_d = halt_after_q;
      for (int i = 0; i < 3; i++) begin
         seq_d[i] = seq_q[i];
      end
      case (st_q)
         FSBC_IDLE: begin
            if (req_valid) begin
               idx_d = 2'd0;
               halt_after_d = 1'b0;
               st_d = FSBC_WRITE;
               case (req.op)
                  fsbc_pkg::OP_PROGRAM: begin
                     if (suspended_q) begin
                        refused_d = 1'b1;
                        st_d = FSBC_IDLE;
                     end else if (bypass_q) begin
                        seq_d[0] = '{fsbc_pkg::ADDR_ANY, fsbc_pkg::CMD_PROG_SETUP}; // RULE14
                        seq_d[1] = '{req.addr, req.data}; // RULE14
                        len_d = 2'd1;
                     end else begin
                        refused_d = 1'b1; // Normal program is outside this block
                        st_d = FSBC_IDLE;
                     end
                  end
                  fsbc_pkg::OP_SUSPEND: begin
                     if (prog_busy && !suspended_q) begin
                        seq_d[0] = '{req.addr, fsbc_pkg::CMD_SUSPEND}; // RULE2
                        len_d = 2'd0;
                        halt_after_d = 1'b1; // RULE1
                        susp_d = 1'b1; // RULE3 RULE4 RULE5
                     end else begin
                        refused_d = 1'b1; // RULE18
                        st_d = FSBC_IDLE;
                     end
                  end
                  fsbc_pkg::OP_RESUME: begin
                     if (suspended_q) begin
                        seq_d[0] = '{req.addr, fsbc_pkg::CMD_RESUME}; // RULE6
                        len_d = 2'd0;
                        susp_d = 1'b0;
                     end else begin
                        refused_d = 1'b1; // RULE7 RULE18
                        st_d = FSBC_IDLE;
                     end
                  end
                  fsbc_pkg::OP_BYP_ENTER: begin
                     if (!bypass_q) begin
                        seq_d[0] = '{fsbc_pkg::ADDR_UNLOCK1, fsbc_pkg::CMD_UNLOCK1}; // RULE17
                        seq_d[1] = '{fsbc_pkg::ADDR_UNLOCK2, fsbc_pkg::CMD_UNLOCK2}; // RULE17
                        seq_d[2] = '{fsbc_pkg::ADDR_UNLOCK1, fsbc_pkg::CMD_BYP_ENTRY}; // RULE17
                        len_d = 2'd2;
                        bypass_d = 1'b1;
                     end else begin
                        refused_d = 1'b1; // RULE19
                        st_d = FSBC_IDLE;
                     end
                  end
                  fsbc_pkg::OP_BYP_EXIT: begin
                     if (bypass_q && !accel_high_q && !prog_busy) begin
                        seq_d[0] = '{fsbc_pkg::ADDR_ANY, fsbc_pkg::CMD_BYP_EXIT1}; // RULE16
                        seq_d[1] = '{fsbc_pkg::ADDR_ANY, fsbc_pkg::CMD_BYP_EXIT2}; // RULE16
                        len_d = 2'd1;
                        bypass_d = 1'b0;
                     end else begin
                        refused_d = 1'b1; // RULE15
                        st_d = FSBC_IDLE;
                     end
                  end
                  fsbc_pkg::OP_ABORT_RST: begin
                     seq_d[0] = '{fsbc_pkg::ADDR_UNLOCK1, fsbc_pkg::CMD_UNLOCK1}; // RULE9
                     seq_d[1] = '{fsbc_pkg::ADDR_UNLOCK2, fsbc_pkg::CMD_UNLOCK2}; // RULE9
                     seq_d[2] = '{fsbc_pkg::ADDR_UNLOCK1, fsbc_pkg::CMD_RESET}; // RULE9
                     len_d = 2'd2;
                  end
                  fsbc_pkg::OP_ACCEL_ON: begin
                     st_d = FSBC_IDLE;
                     if (sectors_unlocked && !accel_high_q && !suspended_q &&
                         accel_count_q < 4'(fsbc_pkg::MAX_ACCEL_PROGS)) begin // RULE11 RULE12
                        accel_d = 1'b1;
                        bypass_d = 1'b1; // RULE8
                        accel_cnt_d = accel_count_q + 4'h1;
                     end else begin
                        refused_d = 1'b1;
                     end
                  end
                  fsbc_pkg::OP_ACCEL_OFF: begin
                     st_d = FSBC_IDLE;
                     if (accel_high_q && !prog_busy) begin
                        accel_d = 1'b0; // RULE10 RULE13
                        bypass_d = 1'b0;
                     end else begin
                        refused_d = 1'b1;
                     end
                  end
                  default: begin
                     refused_d = 1'b1;
                     st_d = FSBC_IDLE;
                  end
               endcase
            end
         end
         FSBC_WRITE: st_d = FSBC_WAIT;
         FSBC_WAIT: begin
            if (wr_done) begin
               if (idx_q != len_q) begin
                  idx_d = idx_q + 2'd1;
                  st_d = FSBC_WRITE;
               end else if (halt_after_q) begin
                  halt_d = 16'(fsbc_pkg::SUSPEND_WAIT_CYC - 1);
                  st_d = FSBC_HALT;
               end else begin
                  st_d = FSBC_IDLE;
               end
            end
         end
         FSBC_HALT: begin
            if (halt_q == 16'h0000) begin
               st_d = FSBC_IDLE; // RULE1
            end else begin
               halt_d = halt_q - 16'h0001;
            end
         end
         default: st_d = FSBC_IDLE;
      endcase
   end

   // Registers
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         st_q <= FSBC_IDLE;
         idx_q <= 2'd0;
         len_q <= 2'd0;
         halt_q <= 16'h0000;
         bypass_q <= 1'b0;
         suspended_q <= 1'b0;
         accel_high_q <= 1'b0;
         accel_count_q <= 4'h0;
         req_refused_q <= 1'b0;
         halt_after_q <= 1'b0;
         for (int i = 0; i < 3; i++) begin
            seq_q[i] <= '0;
         end
      end else begin
         st_q <= st_d;
         idx_q <= idx_d;
         len_q <= len_d;
         halt_q <= halt_d;
         bypass_q <= bypass_d;
         suspended_q <= susp_d;
         accel_high_q <= accel_d;
         accel_count_q <= accel_cnt_d;
         req_refused_q <= refused_d;
         halt_after_q <= halt_after_d;
         for (int i = 0; i < 3; i++) begin
            seq_q[i] <= seq_d[i];
         end
      end
   end

   // Suspend is only taken while programming runs
   suspend_when_busy_a: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE18
      $rose(suspended_q) |-> $past(prog_busy)) else $error("suspend with no program");
   // Resume word reaches the pins right after the suspended flag drops
   resume_from_susp_a: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE6 RULE7
      $fell(suspended_q) |-> ##1 (!flash_ce_n && flash_dq_out == fsbc_pkg::CMD_RESUME))
      else $error("bad resume");
   // Accelerate rises only with unlocked sectors and enters bypass
   accel_rise_a: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE8
      $rose(accel_high_q) |-> bypass_q && $past(sectors_unlocked)) else $error("bad accel rise");
   // Accelerate never drops during programming
   accel_fall_a: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE10
      $fell(accel_high_q) |-> !$past(prog_busy) && !bypass_q) else $error("accel dropped early");
   // Accelerate use count bounded
   accel_limit_a: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE11
      accel_count_q <= 4'(fsbc_pkg::MAX_ACCEL_PROGS)) else $error("accel over limit");
   // Suspend write followed by halt wait before next request
   suspend_halt_a: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE1
      (st_q == FSBC_WAIT && wr_done && halt_after_q) |=> !req_ready [*8])
      else $error("suspend wait skipped");
   // Bypass exit drops the bypass flag only with accel low
   bypass_exit_a: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE16
      $fell(bypass_q) |-> !accel_high_q) else $error("bypass left under accel");
   // Write cycles not sent while idle
   no_stray_write_a: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE19
      (st_q == FSBC_IDLE) |-> ##1 flash_we_n) else $error("stray write");
   // First entry cycle puts the first unlock word on the pins
   entry_first_a: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE17
      $rose(bypass_q) && !accel_high_q |-> ##1 (flash_addr == fsbc_pkg::ADDR_UNLOCK1 &&
      flash_dq_out == fsbc_pkg::CMD_UNLOCK1)) else $error("bad entry sequence");
endmodule // fsbc_host

/* File: rtl/fsbc_pkg.sv */
// Purpose: Shared constants and types for the flash suspend/bypass host controller
// Assumes: 16-bit data bus, word addressing, 100 MHz system clock
// Notes: Bus cycle timing counts derive from nanosecond figures below
package fsbc_pkg;
   // Command data words
   localparam logic [15:0] CMD_UNLOCK1 = 16'h00AA;
   localparam logic [15:0] CMD_UNLOCK2 = 16'h0055;
   localparam logic [15:0] CMD_BYP_ENTRY = 16'h0020;
   localparam logic [15:0] CMD_SUSPEND = 16'h00B0;
   localparam logic [15:0] CMD_RESUME = 16'h0030;
   localparam logic [15:0] CMD_BYP_EXIT1 = 16'h0090;
   localparam logic [15:0] CMD_BYP_EXIT2 = 16'h0000;
   localparam logic [15:0] CMD_PROG_SETUP = 16'h00A0;
   localparam logic [15:0] CMD_RESET = 16'h00F0;
   // Word addresses of the unlock cycles
   localparam logic [23:0] ADDR_UNLOCK1 = 24'h000555;
   localparam logic [23:0] ADDR_UNLOCK2 = 24'h0002AA;
   localparam logic [23:0] ADDR_ANY = 24'h000000;
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int WE_LOW_NS = 35;
   localparam int WE_HIGH_NS = 30;
   localparam int SUSPEND_MAX_US = 15;
   localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WE_HIGH_CYC = (WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SUSPEND_WAIT_CYC = (SUSPEND_MAX_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MAX_ACCEL_PROGS = 10;
   // Host command codes
   localparam logic [2:0] OP_PROGRAM = 3'h0;
   localparam logic [2:0] OP_SUSPEND = 3'h1;
   localparam logic [2:0] OP_RESUME = 3'h2;
   localparam logic [2:0] OP_BYP_ENTER = 3'h3;
   localparam logic [2:0] OP_BYP_EXIT = 3'h4;
   localparam logic [2:0] OP_ABORT_RST = 3'h5;
   localparam logic [2:0] OP_ACCEL_ON = 3'h6;
   localparam logic [2:0] OP_ACCEL_OFF = 3'h7;
   // One bus write cycle
   typedef struct packed {
      logic [23:0] addr;
      logic [15:0] data;
   } fsbc_wr_s;
   // Host request
   typedef struct packed {
      logic [2:0] op;
      logic [23:0] addr;
      logic [15:0] data;
   } fsbc_req_s;
endpackage

/* File: rtl/fsbc_wr_cycle.sv */
// Purpose: Drives one asynchronous write pulse on the flash bus
// Assumes: Chip select, address and data held stable for the whole cycle
// Notes: Busy from start until the high time after the pulse has passed
`timescale 1ns/1ps
module fsbc_wr_cycle (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Request
   input wire logic start,
   input wire fsbc_pkg::fsbc_wr_s wr,
   output logic done,
   // Flash pins
   output logic [23:0] addr_q,
   output logic [15:0] dq_out_q,
   output logic dq_oe_n_q,
   output logic ce_n_q,
   output logic we_n_q
);
   typedef enum logic [1:0] {
      FSBC_W_IDLE = 2'b00,
      FSBC_W_LOW = 2'b01,
      FSBC_W_HIGH = 2'b10
   } fsbc_w_e;
   fsbc_w_e st_q, st_d;
   logic [7:0] cnt_q, cnt_d;
   logic [23:0] addr_d;
   logic [15:0] dq_d;
   logic oe_d, ce_d, we_d, done_d;

   // Next state of the write pulse
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      addr_d = addr_q;
      dq_d = dq_out_q;
      oe_d = dq_oe_n_q;
      ce_d = ce_n_q;
      we_d = we_n_q;
      done_d = 1'b0;
      case (st_q)
         FSBC_W_IDLE: begin
            if (start) begin
               addr_d = wr.addr;
               dq_d = wr.data;
               oe_d = 1'b0;
               ce_d = 1'b0;
               we_d = 1'b0;
               cnt_d = 8'(fsbc_pkg::WE_LOW_CYC - 1);
               st_d = FSBC_W_LOW;
            end
         end
         FSBC_W_LOW: begin
            if (cnt_q == 8'h00) begin
               we_d = 1'b1; // Rising edge latches the data
               cnt_d = 8'(fsbc_pkg::WE_HIGH_CYC - 1);
               st_d = FSBC_W_HIGH;
            end else begin
               cnt_d = cnt_q - 8'h01;
            end
         end
         FSBC_W_HIGH: begin
            if (cnt_q == 8'h00) begin
               ce_d = 1'b1;
               oe_d = 1'b1;
               done_d = 1'b1;
               st_d = FSBC_W_IDLE;
            end else begin
               cnt_d = cnt_q - 8'h01;
            end
         end
         default: st_d = FSBC_W_IDLE;
      endcase
   end

   // Registers
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         st_q <= FSBC_W_IDLE;
         cnt_q <= 8'h00;
         addr_q <= 24'h000000;
         dq_out_q <= 16'h0000;
         dq_oe_n_q <= 1'b1;
         ce_n_q <= 1'b1;
         we_n_q <= 1'b1;
         done <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         addr_q <= addr_d;
         dq_out_q <= dq_d;
         dq_oe_n_q <= oe_d;
         ce_n_q <= ce_d;
         we_n_q <= we_d;
         done <= done_d;
      end
   end

   // Write enable only pulses with chip select low
   we_under_ce_a: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE19
      !we_n_q |-> !ce_n_q) else $error("write pulse without chip select");
endmodule // fsbc_wr_cycle

/* File: testbench/fsbc_flash_model.sv */
// Purpose: Behavioural flash device facing the suspend/bypass host controller
// Assumes: Commands decoded at the rising edge of the write strobe with chip select low
// Notes: Program time shortened by PROG_CYC; array reads are not modelled
`timescale 1ns/1ps
module fsbc_flash_model #(
   parameter int PROG_CYC = 300
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Flash pins
   input wire logic [23:0] flash_addr,
   input wire logic [15:0] flash_dq_out,
   input wire logic flash_ce_n,
   input wire logic flash_we_n,
   input wire logic accel_high,
   output logic prog_busy,
   // Observed device state
   output logic bypass,
   output logic suspended,
   output int wr_count,
   output int aborts,
   output fsbc_pkg::fsbc_wr_s last_wr
);
   fsbc_pkg::fsbc_wr_s h1, h0, w;
   logic we_q, acc_q, want_data;
   int left;
   // Busy while program time remains, frozen while suspended
   assign prog_busy = left != 0;
   assign w = {flash_addr, flash_dq_out};
   // Voltage watch, program timer and command decode
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         we_q <= 1'b1;
         acc_q <= 1'b0;
         want_data <= 1'b0;
         bypass <= 1'b0;
         suspended <= 1'b0;
         left <= 0;
         wr_count <= 0;
         aborts <= 0;
         h0 <= '0;
         h1 <= '0;
         last_wr <= '0;
      end else begin
         we_q <= flash_we_n;
         acc_q <= accel_high;
         if (accel_high && !acc_q) bypass <= 1'b1;
         if (!accel_high && acc_q && left == 0) bypass <= 1'b0;
         if (left != 0 && !suspended) left <= left - 1;
         if (flash_we_n && !we_q && !flash_ce_n) begin
            wr_count <= wr_count + 1;
            last_wr <= w;
            h1 <= h0;
            h0 <= w;
            if (want_data) begin
               left <= PROG_CYC;
               want_data <= 1'b0;
            end else if (w.data == fsbc_pkg::CMD_SUSPEND) begin
               if (left != 0) suspended <= 1'b1;
            end else if (w.data == fsbc_pkg::CMD_RESUME) begin
               suspended <= 1'b0;
            end else if (bypass && w.data == fsbc_pkg::CMD_PROG_SETUP) begin
               want_data <= 1'b1;
            end else if (bypass && h0.data == fsbc_pkg::CMD_BYP_EXIT1
                         && w.data == fsbc_pkg::CMD_BYP_EXIT2) begin
               bypass <= 1'b0;
            end else if (h1 == {fsbc_pkg::ADDR_UNLOCK1, fsbc_pkg::CMD_UNLOCK1}
                         && h0 == {fsbc_pkg::ADDR_UNLOCK2, fsbc_pkg::CMD_UNLOCK2}) begin
               if (!bypass && w == {fsbc_pkg::ADDR_UNLOCK1, fsbc_pkg::CMD_BYP_ENTRY}) bypass <= 1'b1;
               if (bypass && w.data == fsbc_pkg::CMD_RESET) aborts <= aborts + 1;
            end
            // Other writes are discarded
         end
      end
   end
endmodule // fsbc_flash_model

/* File: testbench/tb_top.sv */
// Purpose: Self-checking bench for the flash suspend/bypass host controller
// Assumes: Inputs driven 1 ns after the rising clock edge
// Notes: Hand-written corners, then seeded random requests, then accelerate count
`timescale 1ns/1ps
module tb_top;
   localparam int WR_N [8] = '{2, 1, 1, 3, 2, 3, 0, 0};
   localparam logic [2:0] IDLE_OPS [5] = '{3'h1, 3'h2, 3'h0, 3'h4, 3'h7};
   logic clk_sys, rstn, req_valid, req_ready, req_refused_q, prog_busy, sectors_unlocked;
   logic bypass_q, suspended_q, accel_high_q, flash_dq_oe_n, flash_ce_n, flash_we_n, rf;
   logic m_bypass, m_susp, e_byp, e_susp, e_acc;
   logic [3:0] accel_count_q;
   logic [23:0] flash_addr;
   logic [15:0] flash_dq_out;
   logic [2:0] op;
   fsbc_pkg::fsbc_req_s req;
   fsbc_pkg::fsbc_wr_s m_last;
   int m_wr, m_abort, err_total, comparisons, cycles, seed, n, e_cnt;
   fsbc_host fsbc_host_i (.clk_sys(clk_sys), .rstn(rstn), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .req_refused_q(req_refused_q), .prog_busy(prog_busy),
      .sectors_unlocked(sectors_unlocked), .bypass_q(bypass_q), .suspended_q(suspended_q),
      .accel_count_q(accel_count_q), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
      .flash_dq_oe_n(flash_dq_oe_n), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
      .accel_high_q(accel_high_q));
   fsbc_flash_model #(.PROG_CYC(300)) fsbc_flash_model_i (.clk_sys(clk_sys), .rstn(rstn),
      .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_ce_n(flash_ce_n),
      .flash_we_n(flash_we_n), .accel_high(accel_high_q), .prog_busy(prog_busy),
      .bypass(m_bypass), .suspended(m_susp), .wr_count(m_wr), .aborts(m_abort),
      .last_wr(m_last));
   // Clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // Hang guard
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 60000) begin
         err_total++;
         results();
      end
   end
   // Value comparison
   task automatic chk(input string name, input logic [39:0] exp, input logic [39:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Expected refusal from the tracked modes
   function automatic logic exp_ref(input logic [2:0] o, input logic busy);
      case (o)
         3'h0: return !(e_byp && !e_susp);
         3'h1: return !(busy && !e_susp);
         3'h2: return !e_susp;
         3'h3: return e_byp;
         3'h4: return !e_byp || e_acc || busy;
         3'h5: return 1'b0;
         3'h6: return !(sectors_unlocked && !e_acc && !e_susp && e_cnt < 10);
         default: return !(e_acc && !busy);
      endcase
   endfunction
   // One request held until taken, then wait for ready
   task automatic issue(input logic [2:0] o, input logic [23:0] a, input logic [15:0] d);
      req_valid = 1'b1;
      req = {o, a, d};
      @(posedge clk_sys);
      while (req_ready !== 1'b1) @(posedge clk_sys);
      #1 req_valid = 1'b0;
      rf = req_refused_q;
      n = 0;
      while (req_ready !== 1'b1 && n < 3000) begin
         @(posedge clk_sys);
         #1 n++;
      end
      if (n >= 3000) begin
         err_total++;
         results();
      end
      // One more edge: the far side catches up and strobes never meet
      @(posedge clk_sys);
      #1;
   endtask
   // Request plus all checks
   task automatic step(input logic [2:0] o);
      logic [23:0] a;
      logic [15:0] d;
      logic x;
      int w0;
      int ab0;
      a = 24'($random(seed));
      d = 16'($random(seed));
      w0 = m_wr;
      ab0 = m_abort;
      x = exp_ref(o, prog_busy);
      issue(o, a, d);
      chk("refused", x, rf);
      chk("writes", 40'(x ? 0 : WR_N[o]), 40'(m_wr - w0));
      if (!x) begin
         case (o)
            3'h0: chk("program word", {a, d}, m_last);
            3'h1: begin
               chk("halt wait", 1'b1, 1'(n >= fsbc_pkg::SUSPEND_WAIT_CYC && n < 1530));
               chk("suspend word", {a, fsbc_pkg::CMD_SUSPEND}, m_last);
            end
            3'h2: begin
               chk("resumed busy", 1'b1, prog_busy);
               chk("resume word", {a, fsbc_pkg::CMD_RESUME}, m_last);
            end
            3'h3: begin
               chk("entry", {fsbc_pkg::ADDR_UNLOCK1, fsbc_pkg::CMD_BYP_ENTRY}, m_last);
            end
            3'h4: chk("exit word", 40'(fsbc_pkg::CMD_BYP_EXIT2), 40'(m_last.data));
            3'h5: chk("abort seen", 40'(e_byp), 40'(m_abort - ab0));
            default: ;
         endcase
         case (o)
            3'h1: e_susp = 1'b1;
            3'h2: e_susp = 1'b0;
            3'h3: e_byp = 1'b1;
            3'h4: e_byp = 1'b0;
            3'h6: begin
               e_acc = 1'b1;
               e_byp = 1'b1;
               e_cnt++;
            end
            3'h7: begin
               e_acc = 1'b0;
               e_byp = 1'b0;
            end
            default: ;
         endcase
      end
      chk("bypass", e_byp, bypass_q);
      chk("model bypass", e_byp, m_bypass);
      chk("suspended", {e_susp, e_susp}, {suspended_q, m_susp});
      chk("accel", {e_acc, 4'(e_cnt)}, {accel_high_q, accel_count_q});
      chk("pins idle", 40'h7, {flash_we_n, flash_ce_n, flash_dq_oe_n});
      $display("test op %0d done refused %0d", o, rf);
   endtask
   // Wait for the program to finish
   task automatic wait_prog();
      n = 0;
      while (prog_busy && n < 2000) begin
         @(posedge clk_sys);
         #1 n++;
      end
      if (n >= 2000) begin
         err_total++;
         results();
      end
   endtask
   // Verdict
   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      {rstn, req_valid, sectors_unlocked, e_byp, e_susp, e_acc} = '0;
      req = '0;
      {err_total, comparisons, cycles, e_cnt} = '0;
      seed = 32'hff4d;
      repeat (12) @(posedge clk_sys);
      chk("reset pins", 5'h1F, {req_ready, flash_we_n, flash_ce_n, flash_dq_oe_n, ~accel_high_q});
      #1 rstn = 1'b1;
      for (int i = 0; i < 5; i++) step(IDLE_OPS[i]);
      step(3'h3);
      step(3'h3);
      step(3'h0);
      step(3'h1);
      step(3'h1);
      step(3'h2);
      step(3'h2);
      step(3'h1);
      step(3'h2);
      wait_prog();
      step(3'h5);
      step(3'h4);
      for (int i = 0; i < 40; i++) begin
         op = 3'($random(seed));
         sectors_unlocked = 1'($random(seed));
         if ((op == 3'h0 || op == 3'h5) && (prog_busy || !e_byp)) op = 3'h1;
         step(op);
      end
      if (e_susp) step(3'h2);
      wait_prog();
      if (e_acc) step(3'h7);
      sectors_unlocked = 1'b0;
      step(3'h6);
      sectors_unlocked = 1'b1;
      step(3'h6);
      step(3'h0);
      step(3'h7);
      wait_prog();
      step(3'h7);
      while (e_cnt < 10) begin
         step(3'h6);
         step(3'h7);
      end
      step(3'h6);
      results();
   end
endmodule // tb_top
